// ---- src/nbp_pkg.sv ----
// package: constants and types for the nand block-protection host controller
package nbp_pkg;
  // command opcodes
  localparam logic [7:0] CMD_UNLOCK_LO = 8'h23;
  localparam logic [7:0] CMD_UNLOCK_HI = 8'h24;
  localparam logic [7:0] CMD_LOCK_ALL  = 8'h2A;
  localparam logic [7:0] CMD_LOCKDOWN  = 8'h2C;
  localparam logic [7:0] CMD_STAT_RD   = 8'h7A;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_PG_SETUP  = 8'h80;
  localparam logic [7:0] CMD_PG_CONF   = 8'h10;
  localparam logic [7:0] CMD_ENTRY0    = 8'h4C;
  localparam logic [7:0] CMD_ENTRY1    = 8'h03;
  localparam logic [7:0] CMD_ENTRY2    = 8'h1D;
  localparam logic [7:0] CMD_ENTRY3    = 8'h41;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam int         GRP_LD_BIT    = 4;
  localparam int         STAT_RDY_BIT  = 6;
  localparam int         MAX_PERM_SEQ  = 16;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_ARG       = 4'h4;
  localparam logic [3:0] REG_STAT      = 4'h8;
  localparam logic [3:0] REG_DATA      = 4'hC;
  // ctrl field positions
  localparam int         CTRL_GO       = 0;
  localparam int         CTRL_OP_LSB   = 4;
  // arg field positions
  localparam int         ARG_LB_LSB    = 0;
  localparam int         ARG_UB_LSB    = 12;
  localparam int         ARG_INV       = 24;
  localparam int         ARG_GRP_LSB   = 25;
  localparam int         ARG_GLD       = 29;
  // operations
  localparam logic [2:0] OP_UNLOCK     = 3'h0;
  localparam logic [2:0] OP_LOCK_ALL   = 3'h1;
  localparam logic [2:0] OP_LOCKDOWN   = 3'h2;
  localparam logic [2:0] OP_STAT_RD    = 3'h3;
  localparam logic [2:0] OP_PERM       = 3'h4;
  // bus timing in ns, rounded up to ref clock cycles
  localparam int         CLK_NS        = 10;
  localparam int         WE_PULSE_NS   = 20;
  localparam int         WE_PULSE_CYC  = (WE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] PH_CYC        = 4'(WE_PULSE_CYC);
  localparam logic [31:0] ARG_RST      = 32'h0000_0000;

  // one byte on the multiplexed bus, with its latch enables
  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       rd;
    logic [7:0] dat;
  } nbp_cyc_t;
endpackage

// ---- src/nbp_host.sv ----
// host controller that drives nand block-protection sequences from wishbone
`timescale 1ns/100ps
// What the nand device does and requires
// RQ1: lower-bound unlock always followed by upper-bound
// RQ2: invert flag selects inside or outside range
// RQ3: unlock sends three mapped address cycles
// RQ4: invert flag sent only with upper bound
// RQ5: device forces plane bits for multiplane
// RQ6: block address bit zero selects plane
// RQ7: lock-all protects every block
// RQ8: lock-down freezes volatile protection state
// RQ9: lock-down cleared only by power cycle
// RQ10: write-protect and enable high before lock-down
// RQ11: device ignores volatile commands after lock-down
// RQ12: write-protect low still blocks after lock-down
// RQ13: sixteen groups of four blocks permanent
// RQ14: permanent group never becomes unprotected
// RQ15: no new groups after permanent lock-down
// RQ16: permanent sequences end with reset command
// RQ17: fourth address low nibble selects group
// RQ18: permanent sequence bytes, confirm, then poll
// RQ19: fourth address bit four selects lock-down
// RQ20: no reset while permanent program busy
// RQ21: at most sixteen permanent sequences total
// RQ22: status read sends three addresses, one data
// RQ23: device latches enable input at power-on
// RQ24: long write-protect low relocks before lock-down
// RQ25: status byte reports lock and lock-down bits
// RQ26: device rejects program to protected block
module nbp_host (
  input  wire logic        ref_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             cle_out,
  output logic             ale_out,
  output logic             we_n_out,
  output logic             re_n_out,
  output logic             ce_n_out,
  output logic             wp_n_out,
  output logic             protection_enable_input_out,
  output logic      [7:0]  io_out,
  output logic             io_oe_n_out,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_output_n_in
);
  import nbp_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SET  = 5'b00010,
    ST_LOW  = 5'b00100,
    ST_HIGH = 5'b01000,
    ST_WAIT = 5'b10000
  } nbp_state_t;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] io_s1_ff, io_s2_ff;
  logic       rb_s1_ff, rb_s2_ff;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      io_s1_ff <= 8'h00;
      io_s2_ff <= 8'h00;
      rb_s1_ff <= 1'b0;
      rb_s2_ff <= 1'b0;
    end else begin
      io_s1_ff <= io_in;
      io_s2_ff <= io_s1_ff;
      rb_s1_ff <= ready_busy_output_n_in;
      rb_s2_ff <= rb_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // sequence builder: one bus cycle per step
  // ----------------------------------------------------------------
  logic [31:0] arg_ff;
  logic [2:0]  op_ff;
  logic [4:0]  step_ff;
  logic [11:0] lb, ub;
  logic        inv;
  logic [3:0]  grp;
  logic        gld;
  nbp_cyc_t    cyc;
  logic        last;
  logic        poll;

  assign lb  = arg_ff[ARG_LB_LSB +: 12];
  assign ub  = arg_ff[ARG_UB_LSB +: 12];
  assign inv = arg_ff[ARG_INV];
  assign grp = arg_ff[ARG_GRP_LSB +: 4];
  assign gld = arg_ff[ARG_GLD];

  function automatic nbp_cyc_t cmd_c(input logic [7:0] b);
    cmd_c = '{cle: 1'b1, ale: 1'b0, rd: 1'b0, dat: b};
  endfunction
  function automatic nbp_cyc_t adr_c(input logic [7:0] b);
    adr_c = '{cle: 1'b0, ale: 1'b1, rd: 1'b0, dat: b};
  endfunction

  always_comb begin
    cyc  = cmd_c(CMD_RESET);
    last = 1'b0;
    poll = 1'b0;
    unique case (op_ff)
      OP_UNLOCK: begin
        // lower bound then upper bound, never split
        unique case (step_ff)
          5'd0: cyc = cmd_c(CMD_UNLOCK_LO);                       // RQ1
          5'd1: cyc = adr_c({lb[1:0], 6'h00});                   // RQ3 RQ4 RQ6
          5'd2: cyc = adr_c(lb[9:2]);                            // RQ3
          5'd3: cyc = adr_c({6'h00, lb[11:10]});                 // RQ3
          5'd4: cyc = cmd_c(CMD_UNLOCK_HI);                       // RQ1
          5'd5: cyc = adr_c({ub[1:0], 5'h00, inv});              // RQ2 RQ3 RQ4
          5'd6: cyc = adr_c(ub[9:2]);                            // RQ3
          default: begin
            cyc  = adr_c({6'h00, ub[11:10]});                    // RQ3
            last = 1'b1;
          end
        endcase
      end
      OP_LOCK_ALL: begin
        cyc  = cmd_c(CMD_LOCK_ALL);
        last = 1'b1;
      end
      OP_LOCKDOWN: begin
        cyc  = cmd_c(CMD_LOCKDOWN);                               // RQ10
        last = 1'b1;
      end
      OP_STAT_RD: begin
        unique case (step_ff)
          5'd0: cyc = cmd_c(CMD_STAT_RD);                         // RQ22
          5'd1: cyc = adr_c({lb[1:0], 6'h00});                   // RQ22
          5'd2: cyc = adr_c(lb[9:2]);
          5'd3: cyc = adr_c({6'h00, lb[11:10]});
          default: begin
            cyc  = '{cle: 1'b0, ale: 1'b0, rd: 1'b1, dat: 8'h00};
            last = 1'b1;
          end
        endcase
      end
      OP_PERM: begin
        unique case (step_ff)
          5'd0: cyc = cmd_c(CMD_ENTRY0);                          // RQ18
          5'd1: cyc = cmd_c(CMD_ENTRY1);
          5'd2: cyc = cmd_c(CMD_ENTRY2);
          5'd3: cyc = cmd_c(CMD_ENTRY3);
          5'd4: cyc = cmd_c(CMD_PG_SETUP);
          5'd5, 5'd6, 5'd7, 5'd9: cyc = adr_c(BYTE_ZERO);
          5'd8: cyc = adr_c({3'h0, gld, grp});                    // RQ17 RQ19
          5'd10: begin
            cyc  = cmd_c(CMD_PG_CONF);
            poll = 1'b1;                                          // RQ20
          end
          default: begin
            cyc  = cmd_c(CMD_RESET);                              // RQ16
            last = 1'b1;
          end
        endcase
      end
      // spare codes send one reset command and end: running them would dodge the attempt count
      default: last = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // bus phase engine and register file
  // ----------------------------------------------------------------
  nbp_state_t  st_ff, nxt_st;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [4:0]  nxt_step;
  logic [2:0]  nxt_op;
  logic [31:0] nxt_arg;
  logic [7:0]  rdat_ff, nxt_rdat;
  logic [4:0]  perm_ff, nxt_perm;
  logic        busy_ff, nxt_busy, err_ff, nxt_err;
  logic        cle_ff, ale_ff, we_ff, re_ff, oe_ff;
  logic        nxt_cle, nxt_ale, nxt_we, nxt_re, nxt_oe;
  logic [7:0]  io_ff, nxt_io;
  logic        ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  logic        wb_hit, go;
  logic        pins_ff, nxt_pins;

  assign wb_hit = wb_cyc_in && wb_stb_in && !ack_ff;
  assign go = wb_hit && wb_we_in && wb_adr_in == REG_CTRL && wb_sel_in[0]
              && wb_dat_in[CTRL_GO] && !busy_ff;

  always_comb begin
    nxt_st   = st_ff;
    nxt_cnt  = cnt_ff;
    nxt_step = step_ff;
    nxt_op   = op_ff;
    nxt_arg  = arg_ff;
    nxt_rdat = rdat_ff;
    nxt_perm = perm_ff;
    nxt_busy = busy_ff;
    nxt_err  = err_ff;
    nxt_cle  = cle_ff;
    nxt_ale  = ale_ff;
    nxt_we   = we_ff;
    nxt_re   = re_ff;
    nxt_oe   = oe_ff;
    nxt_io   = io_ff;
    nxt_ack  = wb_hit;
    nxt_dat  = 32'h0;
    nxt_pins = 1'b1;
    if (wb_hit && !wb_we_in) begin
      unique case (wb_adr_in)
        REG_CTRL: nxt_dat = {29'h0, op_ff};
        REG_ARG:  nxt_dat = arg_ff;
        REG_STAT: nxt_dat = {24'h0, perm_ff, err_ff, rb_s2_ff, busy_ff};
        REG_DATA: nxt_dat = {24'h0, rdat_ff};
        default:  nxt_dat = 32'h0;
      endcase
    end
    if (wb_hit && wb_we_in && wb_adr_in == REG_ARG && !busy_ff) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_in[i]) nxt_arg[i*8 +: 8] = wb_dat_in[i*8 +: 8];
      end
    end
    unique case (st_ff)
      ST_IDLE: begin
        if (go) begin
          nxt_op   = wb_dat_in[CTRL_OP_LSB +: 3];
          nxt_step = 5'd0;
          nxt_err  = 1'b0;
          // count attempts; refuse beyond the device's limit
          if (wb_dat_in[CTRL_OP_LSB +: 3] == OP_PERM &&
              perm_ff == 5'(MAX_PERM_SEQ)) begin                  // RQ21
            nxt_err = 1'b1;
          end else begin
            if (wb_dat_in[CTRL_OP_LSB +: 3] == OP_PERM)
              nxt_perm = perm_ff + 5'd1;                          // RQ21
            nxt_busy = 1'b1;
            nxt_st   = ST_SET;
          end
        end
      end
      ST_SET: begin
        nxt_cle = cyc.cle;
        nxt_ale = cyc.ale;
        nxt_io  = cyc.dat;
        nxt_oe  = cyc.rd;
        nxt_cnt = PH_CYC;
        nxt_st  = ST_LOW;
      end
      ST_LOW: begin
        nxt_we = !cyc.rd;
        nxt_re = cyc.rd;
        if (cnt_ff == 4'd0) begin
          nxt_cnt = PH_CYC;
          nxt_st  = ST_HIGH;
        end else begin
          nxt_cnt = cnt_ff - 4'd1;
        end
      end
      ST_HIGH: begin
        if (nxt_re || re_ff) nxt_rdat = io_s2_ff;                 // RQ25
        nxt_we = 1'b0;
        nxt_re = 1'b0;
        if (cnt_ff == 4'd0) begin
          nxt_cle  = 1'b0;
          nxt_ale  = 1'b0;
          nxt_oe   = 1'b0;
          nxt_step = step_ff + 5'd1;
          nxt_cnt  = PH_CYC;
          if (last) begin
            nxt_busy = 1'b0;
            nxt_st   = ST_IDLE;
          end else if (poll) begin
            nxt_st = ST_WAIT;
          end else begin
            nxt_st = ST_SET;
          end
        end else begin
          nxt_cnt = cnt_ff - 4'd1;
        end
      end
      ST_WAIT: begin
        // hold off the reset until the program finishes
        if (cnt_ff != 4'd0) nxt_cnt = cnt_ff - 4'd1;
        else if (rb_s2_ff) nxt_st = ST_SET;                       // RQ20
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff   <= ST_IDLE;
      cnt_ff  <= 4'h0;
      step_ff <= 5'h00;
      op_ff   <= OP_UNLOCK;
      arg_ff  <= ARG_RST;
      rdat_ff <= 8'h00;
      perm_ff <= 5'h00;
      busy_ff <= 1'b0;
      err_ff  <= 1'b0;
      cle_ff  <= 1'b0;
      ale_ff  <= 1'b0;
      we_ff   <= 1'b0;
      re_ff   <= 1'b0;
      oe_ff   <= 1'b0;
      io_ff   <= 8'h00;
      ack_ff  <= 1'b0;
      dat_ff  <= 32'h0;
      pins_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      cnt_ff  <= nxt_cnt;
      step_ff <= nxt_step;
      op_ff   <= nxt_op;
      arg_ff  <= nxt_arg;
      rdat_ff <= nxt_rdat;
      perm_ff <= nxt_perm;
      busy_ff <= nxt_busy;
      err_ff  <= nxt_err;
      cle_ff  <= nxt_cle;
      ale_ff  <= nxt_ale;
      we_ff   <= nxt_we;
      re_ff   <= nxt_re;
      oe_ff   <= nxt_oe;
      io_ff   <= nxt_io;
      ack_ff  <= nxt_ack;
      dat_ff  <= nxt_dat;
      pins_ff <= nxt_pins;
    end
  end

  // write-protect and enable go high on the first clock after reset release: an idle low
  // on write-protect would relock the range, and lock-down needs both high
  assign cle_out    = cle_ff;
  assign ale_out    = ale_ff;
  assign we_n_out   = !we_ff;
  assign re_n_out   = !re_ff;
  assign ce_n_out   = !busy_ff;
  assign wp_n_out   = pins_ff;                                    // RQ10
  assign protection_enable_input_out = pins_ff;                   // RQ10
  assign io_out     = io_ff;
  assign io_oe_n_out = oe_ff;
  assign wb_ack_out = ack_ff;
  assign wb_dat_out = dat_ff;
endmodule

// ---- test/nbp_host_properties.sv ----
// checker: port properties of the block-protection host
`timescale 1ns/100ps
module nbp_host_properties
  import nbp_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       rstn_in,
  input wire logic       wb_cyc_in,
  input wire logic       wb_stb_in,
  input wire logic       wb_ack_out,
  input wire logic       cle_out,
  input wire logic       ale_out,
  input wire logic       we_n_out,
  input wire logic       re_n_out,
  input wire logic       wp_n_out,
  input wire logic       protection_enable_input_out,
  input wire logic [7:0] io_out,
  input wire logic       io_oe_n_out
);
  // --------
  // checks
  // --------
  default clocking dc @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  AST_ACK_NEXT:
    assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
      else $error("ack late");
  AST_ACK_ONCE:
    assert property (wb_ack_out |=> !wb_ack_out) else $error("ack long");
  AST_ACK_CAUSE:
    assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in) && $past(wb_stb_in))
      else $error("ack no request");
  AST_LATCH_EXCL:
    assert property (!(cle_out && ale_out)) else $error("cle with ale");
  AST_WE_WIDTH:
    assert property ($fell(we_n_out) |-> !we_n_out [*3] ##1 we_n_out)
      else $error("strobe width");
  AST_IO_STANDS:
    assert property (!we_n_out |=> $stable(io_out)) else $error("io moved");
  AST_LD_PINS:
    assert property (cle_out && !we_n_out && io_out == CMD_LOCKDOWN
      |-> wp_n_out && protection_enable_input_out) else $error("ld pins");
  AST_READ_FREE:
    assert property (!re_n_out |-> io_oe_n_out && !cle_out && !ale_out)
      else $error("read drive");
  CVR_LD: cover property (cle_out && io_out == CMD_LOCKDOWN);
  CVR_RD: cover property ($rose(re_n_out));
  CVR_ACK: cover property (wb_ack_out);
endmodule

bind nbp_host nbp_host_properties i_nbp_host_properties (
  .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out), .cle_out(cle_out),
  .ale_out(ale_out), .we_n_out(we_n_out), .re_n_out(re_n_out),
  .wp_n_out(wp_n_out), .io_out(io_out), .io_oe_n_out(io_oe_n_out),
  .protection_enable_input_out(protection_enable_input_out));

// ---- test/nbp_nand_model.sv ----
// behavioural die: range and group protection with status read
`timescale 1ns/100ps
module nbp_nand_model
  import nbp_pkg::*;
#(
  parameter int BUSY_NS = 300,
  parameter int HOLD_NS = 30
) (
  input  wire logic       cle_in,
  input  wire logic       ale_in,
  input  wire logic       we_n_in,
  input  wire logic       re_n_in,
  input  wire logic       ce_n_in,
  input  wire logic       wp_n_in,
  input  wire logic       pe_in,
  input  wire logic [7:0] io_in,
  output logic      [7:0] io_out,
  output logic            rb_n_out
);
  // ----------
  // state
  // ----------
  // powered up with enable high, so every block starts locked
  logic [9:0]  log_q[$];
  logic [11:0] lb = '0, ub = '0, ba = '0, blk = '0;
  logic [39:0] hist = '0;
  logic [15:0] grp = '0;
  logic [7:0]  cmd = '0, sb = '0, g = '0;
  logic        inv = '0, flg = '0, ropen = '0, vld = '0, pld = '0;
  logic        drv = '0, host_bad = '0;
  int          na = 0;
  initial rb_n_out = '1;
  function automatic logic [7:0] stat(input logic [11:0] b);
    logic un;
    un = ropen && (inv ? (b < lb || b > ub) : (b >= lb && b <= ub));
    return {3'h0, pld, !(b < 12'h040 && grp[b[5:2]]), un, !vld, vld};
  endfunction
  always @(posedge we_n_in) if (!ce_n_in) begin
    log_q.push_back({cle_in, ale_in, io_in});
    if (cle_in) begin
      host_bad |= io_in == CMD_RESET && !rb_n_out;
      if (io_in == CMD_LOCK_ALL && !vld) ropen = '0;
      if (io_in == CMD_LOCKDOWN) begin
        vld = '1;
        host_bad |= !(wp_n_in && pe_in);
      end
      if (io_in == CMD_PG_CONF && hist == {CMD_ENTRY0, CMD_ENTRY1,
          CMD_ENTRY2, CMD_ENTRY3, CMD_PG_SETUP}) begin
        if (!pld) grp[g[3:0]] = '1;
        pld |= g[GRP_LD_BIT];
        rb_n_out = '0;
        rb_n_out <= #BUSY_NS '1;
      end
      hist = {hist[31:0], io_in};
      cmd = io_in;
      na = 0;
    end else if (ale_in) begin
      case (na)
        0: {ba[1:0], flg} = {io_in[7:6], io_in[0]};
        1: ba[9:2] = io_in;
        2: ba[11:10] = io_in[1:0];
        // only the fourth byte names the group; the trailing zero must not
        3: g = io_in;
        default: ;
      endcase
      if (na == 2 && cmd == CMD_STAT_RD) blk = ba;
      if (na == 2 && !vld && cmd == CMD_UNLOCK_LO) lb = ba;
      if (na == 2 && !vld && cmd == CMD_UNLOCK_HI)
        {ub, inv, ropen} = {ba, flg, 1'b1};
      na++;
    end
  end
  // a long low on write-protect drops the range until lock-down
  always @(negedge wp_n_in) begin
    #101;
    if (!wp_n_in && !vld) ropen = '0;
  end
  always @(negedge re_n_in) begin
    sb = stat(blk);
    drv = '1;
  end
  always @(posedge re_n_in) drv <= #HOLD_NS '0;
  // past the hold time the bus shows garbage, not the stale byte
  assign io_out = drv ? sb : ~sb;
endmodule

// ---- test/nbp_host_tb.sv ----
// self-checking bench for the block-protection host
`timescale 1ns/100ps
module nbp_host_tb;
  import nbp_pkg::*;
  logic        clk = '0, rstn = '0, cyc = '0, we = '0;
  logic        ack, cle, ale, we_n, re_n, ce_n, wp_n, pe, oe_n, rb_n;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [7:0]  io_h, io_d;
  logic [9:0]  exp_q[$];
  int          fails = 0, samples_checked = 0;
  always #5 clk = ~clk;
  nbp_host i_nbp_host (.ref_clk_in(clk), .rstn_in(rstn), .wb_adr_in(adr),
    .wb_dat_in(wdat), .wb_we_in(we), .wb_sel_in(4'hF), .wb_cyc_in(cyc),
    .wb_stb_in(cyc), .wb_dat_out(rdat), .wb_ack_out(ack), .cle_out(cle),
    .ale_out(ale), .we_n_out(we_n), .re_n_out(re_n), .ce_n_out(ce_n),
    .wp_n_out(wp_n), .protection_enable_input_out(pe), .io_out(io_h),
    .io_oe_n_out(oe_n), .io_in(io_d), .ready_busy_output_n_in(rb_n));
  nbp_nand_model i_nbp_nand_model (.cle_in(cle), .ale_in(ale),
    .we_n_in(we_n), .re_n_in(re_n), .ce_n_in(ce_n), .wp_n_in(wp_n),
    .pe_in(pe), .io_in(io_h), .io_out(io_d), .rb_n_out(rb_n));
  // ----------
  // tasks
  // ----------
  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= '1;
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) fails++;
    q = rdat;
    cyc <= '0;
    @(posedge clk);
  endtask
  function automatic void ec(input logic [7:0] b);
    exp_q.push_back({2'h2, b});
  endfunction
  function automatic void ea(input logic [7:0] b);
    exp_q.push_back({2'h1, b});
  endfunction
  function automatic void eb(input logic [11:0] b, input logic f);
    ea({b[1:0], 5'h00, f});
    ea(b[9:2]);
    ea({6'h00, b[11:10]});
  endfunction
  task automatic chk_log(input string n);
    chk(n, 32'(exp_q.size()), 32'(i_nbp_nand_model.log_q.size()));
    foreach (exp_q[i])
      if (i < i_nbp_nand_model.log_q.size())
        chk(n, 32'(exp_q[i]), 32'(i_nbp_nand_model.log_q[i]));
    exp_q.delete();
  endtask
  task automatic op(input logic [2:0] o, input logic [31:0] arg);
    int n;
    n = 0;
    i_nbp_nand_model.log_q.delete();
    wb(REG_ARG, '1, arg);
    wb(REG_CTRL, '1, {25'h0, o, 4'h1});
    do begin
      wb(REG_STAT, '0, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (n == 500) fails++;
  endtask
  task automatic st(input logic [11:0] b, input logic [7:0] e);
    op(OP_STAT_RD, {20'h0, b});
    wb(REG_DATA, '0, 32'h0);
    chk("blk status", {24'h0, e}, q);
  endtask
  task automatic unl(input logic [11:0] lo, hi, input logic i);
    op(OP_UNLOCK, {7'h0, i, hi, lo});
    ec(CMD_UNLOCK_LO);
    eb(lo, '0);
    ec(CMD_UNLOCK_HI);
    eb(hi, i);
    chk_log("unlock");
  endtask
  task automatic perm(input logic [3:0] gr, input logic ld, ok);
    logic [7:0] pre[5];
    pre = '{CMD_ENTRY0, CMD_ENTRY1, CMD_ENTRY2, CMD_ENTRY3, CMD_PG_SETUP};
    op(OP_PERM, {2'h0, ld, gr, 25'h0});
    foreach (pre[i]) ec(pre[i]);
    for (int i = 0; i < 5; i++) ea(i == 3 ? {3'h0, ld, gr} : 8'h00);
    ec(CMD_PG_CONF);
    ec(CMD_RESET);
    if (!ok) exp_q.delete();
    chk_log("perm seq");
  endtask
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (20) @(posedge clk);
    rstn <= '1;
    // let the ready flag pass its two synchroniser stages first
    repeat (3) @(posedge clk);
    wb(REG_STAT, '0, 32'h0);
    chk("stat", 32'h2, q);
    wb(REG_ARG, '0, 32'h0);
    chk("arg", ARG_RST, q);
    wb(4'h2, '0, 32'h0);
    chk("unmapped", 32'h0, q);
    st(12'h005, 8'h0A);
    ec(CMD_STAT_RD);
    eb(12'h005, '0);
    chk_log("stat read");
    unl(12'h5A3, 12'hABC, '1);
    st(12'h600, 8'h0A);
    st(12'h5A3, 8'h0A);
    st(12'h001, 8'h0E);
    unl(12'h004, 12'h007, '0);
    st(12'h007, 8'h0E);
    st(12'h008, 8'h0A);
    op(OP_LOCK_ALL, 32'h0);
    ec(CMD_LOCK_ALL);
    chk_log("lock all");
    st(12'h004, 8'h0A);
    unl(12'h004, 12'h007, '0);
    op(OP_LOCKDOWN, 32'h0);
    ec(CMD_LOCKDOWN);
    chk_log("lockdown");
    unl(12'h008, 12'h009, '0);
    op(OP_LOCK_ALL, 32'h0);
    st(12'h007, 8'h0D);
    st(12'h008, 8'h09);
    perm(4'h3, '0, '1);
    st(12'h00D, 8'h01);
    wb(REG_STAT, '0, 32'h0);
    chk("attempts", 32'h0A, q);
    perm(4'hF, '1, '1);
    st(12'h03C, 8'h11);
    perm(4'h0, '0, '1);
    st(12'h000, 8'h19);
    repeat (13) perm(4'h1, '0, '1);
    perm(4'h2, '0, '0);
    wb(REG_STAT, '0, 32'h0);
    chk("refused", 32'h4, q & 32'h4);
    chk("host pins", 32'h0, {31'h0, i_nbp_nand_model.host_bad});
    close_out();
  end
  initial begin
    #500000;
    fails++;
    close_out();
  end
endmodule
